// >>> src/deac_pkg.sv
// shared constants for the data store access controller
package deac_pkg;
  // register offsets on the cpu-side special register port
  localparam logic [7:0] DEAC_OFS_DATA = 8'h9A;
  localparam logic [7:0] DEAC_OFS_ADDR = 8'h9B;
  localparam logic [7:0] DEAC_OFS_CTRL = 8'h9C;
  localparam logic [7:0] DEAC_OFS_KEY = 8'h9D;
  // control register bit positions
  localparam int DEAC_BIT_RD = 0;
  localparam int DEAC_BIT_WR = 1;
  localparam int DEAC_BIT_PERMIT = 2;
  localparam int DEAC_BIT_ABORT = 3;
  // unlock key values
  localparam logic [7:0] DEAC_KEY_FIRST = 8'h55;
  localparam logic [7:0] DEAC_KEY_SECOND = 8'hAA;
  // clock and timing
  localparam int DEAC_CLK_HZ = 20_000_000;
  localparam int DEAC_CLK_NS = 1_000_000_000 / DEAC_CLK_HZ;
  // write cycle time in nanoseconds and its cycle count (least time, rounded up)
  localparam int DEAC_WRITE_NS = 5_000_000;
  localparam int DEAC_WRITE_CYC = (DEAC_WRITE_NS + DEAC_CLK_NS - 1) / DEAC_CLK_NS;
  // power-up delay 64 ms
  localparam int DEAC_POWERUP_DELAY_TIMER_MS = 64;
  localparam int DEAC_POWERUP_DELAY_TIMER_CYC = DEAC_POWERUP_DELAY_TIMER_MS * (DEAC_CLK_HZ / 1000);
  // cycles between the two key writes and between second key and trigger
  localparam logic [1:0] DEAC_KEY_GAP = 2'h2;
  // apb offsets of the host's own registers
  localparam logic [11:0] DEAC_HOFS_CMD = 12'h000;
  localparam logic [11:0] DEAC_HOFS_ADDR = 12'h004;
  localparam logic [11:0] DEAC_HOFS_WDATA = 12'h008;
  localparam logic [11:0] DEAC_HOFS_STAT = 12'h00C;
  // host command codes
  localparam logic [1:0] DEAC_CMD_READ = 2'h1;
  localparam logic [1:0] DEAC_CMD_WRITE = 2'h2;
  localparam logic [1:0] DEAC_CMD_CLRFLAG = 2'h3;
  // write engine states, gray along idle, erase, program
  typedef enum logic [1:0] {
    DEAC_W_IDLE = 2'b00,
    DEAC_W_ERASE = 2'b01,
    DEAC_W_PROG = 2'b11
  } deac_wstate_t;
endpackage : deac_pkg

// >>> src/deac_if.sv
// special register port joining the cpu-side host and the controller
`timescale 1ns/1ps
`default_nettype none
interface deac_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic done_flag;
  logic done_clr;
  modport dev (input wr_en, input rd_en, input addr, input wdata, input done_clr,
    output rdata, output done_flag);
  modport host (output wr_en, output rd_en, output addr, output wdata, output done_clr,
    input rdata, input done_flag);
endinterface : deac_if
`default_nettype wire

// >>> src/deac_dev.sv
// data store access controller: register file, unlock logic, write engine, array
// Contract
// - each byte write erases then programs
// - data byte and location select registers
// - 256 or 64 bytes, top bit zero
// - internal timer ends write, trigger held
// - protection zeroes programmer reads only
// - control upper four bits read zero
// - triggers set-only, hardware clears them
// - write permit resets to zero
// - aborted write sets abort flag
// - aborting reset clears data and address
// - completion clears trigger, sets done flag
// - unlock register stores nothing, reads zero
// - software leaves registers alone during write
// - read data ready next cycle
// - data byte kept until read or write
// - 55h, AAh, trigger exact order
// - exact cycle spacing across unlock sequence
// - trigger ignored without write permit
// - permit never cleared by hardware
// - no writes during power-up delay
// - software masks interrupts, keeps permit clear
`timescale 1ns/1ps
`default_nettype none
module deac_dev
  import deac_pkg::*;
#(
  parameter bit LARGE = 1'b1,
  parameter int POWERUP_DELAY_TIMER_CYC = DEAC_POWERUP_DELAY_TIMER_CYC,
  parameter int WRITE_CYC = DEAC_WRITE_CYC
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // reset causes seen by the controller (held with presetn low)
  input wire logic master_clear_reset,
  input wire logic watchdog_timer,
  input wire logic brownout_detect,
  input wire logic power_on,
  // configuration and programmer port
  input wire logic data_protect_fuse,
  input wire logic prog_rd,
  input wire logic [7:0] prog_addr,
  output logic [7:0] prog_rdata,
  // cpu special register port
  deac_if.dev bus
);
  localparam int DEPTH = 256;
  localparam int PW = $clog2(POWERUP_DELAY_TIMER_CYC + 1);
  localparam int WW = $clog2(WRITE_CYC + 1);

  logic [7:0] mem [DEPTH];
  logic [7:0] data_byte_reg;
  logic [7:0] location_select_reg;
  logic write_permit;
  logic write_abort_flag;
  logic wr_trig_reg;
  logic rd_trig_reg;
  logic done_reg;
  logic [7:0] rdata_reg;
  logic [7:0] prog_rdata_reg;
  logic [1:0] key_stage_reg;
  logic [1:0] key_gap_reg;
  logic [PW-1:0] powerup_delay_timer_cnt_reg;
  logic [WW-1:0] wcnt_reg;
  deac_wstate_t wstate_reg;
  logic [7:0] waddr_reg;
  logic [7:0] wdata_reg;
  logic busy_reg;

  // location mask: small variant drops the top bit
  function automatic logic [7:0] mask_loc(input logic [7:0] a);
    mask_loc = LARGE ? a : {1'b0, a[6:0]};
  endfunction : mask_loc

  // array index: the small variant wraps at its 64 locations
  function automatic logic [7:0] mem_idx(input logic [7:0] a);
    mem_idx = LARGE ? a : {2'b00, a[5:0]};
  endfunction : mem_idx

  function automatic logic [7:0] ctrl_value(input logic ab, input logic pm, input logic w,
      input logic r);
    ctrl_value = {4'h0, ab, pm, w, r};
  endfunction : ctrl_value

  wire logic wr_data = clk_en && bus.wr_en && bus.addr == DEAC_OFS_DATA;
  wire logic wr_addr = clk_en && bus.wr_en && bus.addr == DEAC_OFS_ADDR;
  wire logic wr_ctrl = clk_en && bus.wr_en && bus.addr == DEAC_OFS_CTRL;
  wire logic wr_key = clk_en && bus.wr_en && bus.addr == DEAC_OFS_KEY;
  wire logic powerup_delay_timer_busy = powerup_delay_timer_cnt_reg != PW'(0);
  // trigger is armed only after both keys at the exact spacing
  wire logic unlocked = key_stage_reg == 2'h2 && key_gap_reg == DEAC_KEY_GAP;
  wire logic start_wr = wr_ctrl && bus.wdata[DEAC_BIT_WR] && write_permit && unlocked
    && !busy_reg && !powerup_delay_timer_busy;
  wire logic start_rd = wr_ctrl && bus.wdata[DEAC_BIT_RD] && !busy_reg;
  wire logic wr_finish = wstate_reg == DEAC_W_PROG && wcnt_reg == WW'(0);
  wire logic cut_by_reset = clk_en && busy_reg
    && (master_clear_reset || watchdog_timer || brownout_detect);

  // power-up delay counter, reloaded on every presetn reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerup_delay_timer_cnt_reg <= PW'(POWERUP_DELAY_TIMER_CYC);
    end else if (clk_en && powerup_delay_timer_busy) begin
      powerup_delay_timer_cnt_reg <= powerup_delay_timer_cnt_reg - PW'(1);
    end
  end

  // abort flag: kept off presetn, or the reset that cuts a write would wipe
  // the flag it sets; only power-on or software clears it; the set wins over software, power-on wins over the set
  always_ff @(posedge pclk) begin
    if (power_on) begin
      write_abort_flag <= 1'b0;
    end else if (cut_by_reset) begin
      write_abort_flag <= 1'b1;
    end else if (wr_ctrl) begin
      write_abort_flag <= bus.wdata[DEAC_BIT_ABORT];
    end
  end

  // write permit: software only, hardware never clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_permit <= 1'b0;
    end else if (wr_ctrl) begin
      write_permit <= bus.wdata[DEAC_BIT_PERMIT];
    end
  end

  // unlock sequence tracker; any other write on the port breaks it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_stage_reg <= 2'h0;
      key_gap_reg <= 2'h0;
    end else if (clk_en) begin
      if (wr_key && bus.wdata == DEAC_KEY_FIRST) begin
        key_stage_reg <= 2'h1;
        key_gap_reg <= 2'h0;
      end else if (wr_key && key_stage_reg == 2'h1 && key_gap_reg == DEAC_KEY_GAP) begin
        key_stage_reg <= bus.wdata == DEAC_KEY_SECOND ? 2'h2 : 2'h0;
        key_gap_reg <= 2'h0;
      end else if (bus.wr_en || key_gap_reg == DEAC_KEY_GAP) begin
        key_stage_reg <= 2'h0;
        key_gap_reg <= 2'h0;
      end else if (key_stage_reg != 2'h0) begin
        key_gap_reg <= key_gap_reg + 2'h1;
      end
    end
  end

  // write engine: erase then program, timed by its own counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wstate_reg <= DEAC_W_IDLE;
      wcnt_reg <= WW'(0);
      busy_reg <= 1'b0;
      wr_trig_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
    end else if (clk_en) begin
      case (wstate_reg)
        DEAC_W_IDLE: begin
          if (start_wr) begin
            wstate_reg <= DEAC_W_ERASE;
            waddr_reg <= mem_idx(location_select_reg);
            wdata_reg <= data_byte_reg;
            busy_reg <= 1'b1;
            wr_trig_reg <= 1'b1;
            wcnt_reg <= WW'(WRITE_CYC / 2);
          end
        end
        DEAC_W_ERASE: begin
          if (wcnt_reg == WW'(0)) begin
            wstate_reg <= DEAC_W_PROG;
            wcnt_reg <= WW'(WRITE_CYC - WRITE_CYC / 2);
          end else begin
            wcnt_reg <= wcnt_reg - WW'(1);
          end
        end
        DEAC_W_PROG: begin
          if (wr_finish) begin
            wstate_reg <= DEAC_W_IDLE;
            busy_reg <= 1'b0;
            wr_trig_reg <= 1'b0;
          end else begin
            wcnt_reg <= wcnt_reg - WW'(1);
          end
        end
        default: wstate_reg <= DEAC_W_IDLE;
      endcase
    end
  end

  // array: erase writes ones, program writes the latched byte
  always_ff @(posedge pclk) begin
    if (clk_en && wstate_reg == DEAC_W_ERASE && wcnt_reg == WW'(0)) begin
      mem[waddr_reg] <= 8'hFF;
    end else if (clk_en && wr_finish) begin
      mem[waddr_reg] <= wdata_reg;
    end
  end

  // completion flag: set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (clk_en && wr_finish) begin
      done_reg <= 1'b1;
    end else if (clk_en && bus.done_clr) begin
      done_reg <= 1'b0;
    end
  end

  // data and address registers; reset clears them, so aborted writes need reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_byte_reg <= 8'h00;
      location_select_reg <= 8'h00;
      rd_trig_reg <= 1'b0;
    end else if (clk_en) begin
      rd_trig_reg <= start_rd;
      if (wr_addr) begin
        location_select_reg <= mask_loc(bus.wdata);
      end
      if (start_rd) begin
        data_byte_reg <= mem[mem_idx(location_select_reg)];
      end else if (wr_data) begin
        data_byte_reg <= bus.wdata;
      end
    end
  end

  // read mux registered; unlock register holds no storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      case (bus.addr)
        DEAC_OFS_DATA: rdata_reg <= data_byte_reg;
        DEAC_OFS_ADDR: rdata_reg <= location_select_reg;
        DEAC_OFS_CTRL: rdata_reg <= ctrl_value(write_abort_flag, write_permit, wr_trig_reg,
          rd_trig_reg);
        DEAC_OFS_KEY: rdata_reg <= 8'h00;
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  // programmer read port, blanked under data protection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_rdata_reg <= 8'h00;
    end else if (clk_en && prog_rd) begin
      prog_rdata_reg <= data_protect_fuse ? 8'h00 : mem[mem_idx(prog_addr)];
    end
  end

  assign bus.rdata = rdata_reg;
  assign bus.done_flag = done_reg;
  assign prog_rdata = prog_rdata_reg;
endmodule : deac_dev
`default_nettype wire

// >>> src/deac_host.sv
// cpu-side host: apb registers turned into timed special register sequences
`timescale 1ns/1ps
`default_nettype none
module deac_host
  import deac_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // special register port toward the controller
  deac_if.host bus
);
  logic [7:0] addr_reg;
  logic [7:0] wdat_reg;
  logic [7:0] rbyte_reg;
  logic [3:0] step_reg;
  logic [1:0] cmd_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic wr_en_reg;
  logic rd_en_reg;
  logic [7:0] sa_reg;
  logic [7:0] sd_reg;
  logic clr_reg;

  wire logic acc = psel && penable && !pready_reg && clk_en;
  wire logic busy = step_reg != 4'h0;

  // apb answers one cycle after the access phase starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      addr_reg <= 8'h00;
      wdat_reg <= 8'h00;
    end else if (clk_en) begin
      pready_reg <= acc;
      if (acc && pwrite && paddr == DEAC_HOFS_ADDR) begin
        addr_reg <= pwdata[7:0];
      end
      if (acc && pwrite && paddr == DEAC_HOFS_WDATA) begin
        wdat_reg <= pwdata[7:0];
      end
      if (acc && !pwrite) begin
        case (paddr)
          DEAC_HOFS_ADDR: prdata_reg <= {24'h000000, addr_reg};
          DEAC_HOFS_WDATA: prdata_reg <= {24'h000000, rbyte_reg};
          DEAC_HOFS_STAT: prdata_reg <= {29'h0, bus.done_flag, bus.rdata[DEAC_BIT_ABORT], busy};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // sequencer: one special register access per cycle, fixed spacing for the key
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_reg <= 4'h0;
      cmd_reg <= 2'h0;
      wr_en_reg <= 1'b0;
      rd_en_reg <= 1'b0;
      // parked on control so status shows the abort flag after any reset
      sa_reg <= DEAC_OFS_CTRL;
      sd_reg <= 8'h00;
      clr_reg <= 1'b0;
      rbyte_reg <= 8'h00;
    end else if (clk_en) begin
      wr_en_reg <= 1'b0;
      rd_en_reg <= 1'b0;
      clr_reg <= 1'b0;
      if (!busy && acc && pwrite && paddr == DEAC_HOFS_CMD) begin
        cmd_reg <= pwdata[1:0];
        step_reg <= 4'h1;
      end else if (busy) begin
        step_reg <= step_reg + 4'h1;
        case ({cmd_reg, step_reg})
          {DEAC_CMD_CLRFLAG, 4'h1}: begin
            clr_reg <= 1'b1;
            step_reg <= 4'h0;
          end
          {DEAC_CMD_READ, 4'h1}, {DEAC_CMD_WRITE, 4'h1}: begin
            wr_en_reg <= 1'b1;
            sa_reg <= DEAC_OFS_ADDR;
            sd_reg <= addr_reg;
          end
          {DEAC_CMD_READ, 4'h2}: begin
            wr_en_reg <= 1'b1;
            sa_reg <= DEAC_OFS_CTRL;
            sd_reg <= 8'h01;
          end
          {DEAC_CMD_READ, 4'h3}: sa_reg <= DEAC_OFS_DATA;
          {DEAC_CMD_READ, 4'h5}: begin
            rbyte_reg <= bus.rdata;
            sa_reg <= DEAC_OFS_CTRL;
            step_reg <= 4'h0;
          end
          {DEAC_CMD_WRITE, 4'h2}: begin
            wr_en_reg <= 1'b1;
            sa_reg <= DEAC_OFS_DATA;
            sd_reg <= wdat_reg;
          end
          {DEAC_CMD_WRITE, 4'h3}: begin
            wr_en_reg <= 1'b1;
            sa_reg <= DEAC_OFS_CTRL;
            // abort bit written clear: a retry clears the flag, as software would
            sd_reg <= 8'h04;
          end
          {DEAC_CMD_WRITE, 4'h4}: begin
            wr_en_reg <= 1'b1;
            sa_reg <= DEAC_OFS_KEY;
            sd_reg <= DEAC_KEY_FIRST;
          end
          {DEAC_CMD_WRITE, 4'h7}: begin
            wr_en_reg <= 1'b1;
            sa_reg <= DEAC_OFS_KEY;
            sd_reg <= DEAC_KEY_SECOND;
          end
          {DEAC_CMD_WRITE, 4'hA}: begin
            wr_en_reg <= 1'b1;
            sa_reg <= DEAC_OFS_CTRL;
            sd_reg <= 8'h06;
          end
          {DEAC_CMD_WRITE, 4'hB}: begin
            sa_reg <= DEAC_OFS_CTRL;
          end
          {DEAC_CMD_WRITE, 4'hD}: begin
            // read-back lags the trigger by two cycles, so polling starts here;
            // poll until the trigger drops, then drop the permit
            if (bus.rdata[DEAC_BIT_WR]) begin
              step_reg <= 4'hD;
            end else begin
              wr_en_reg <= 1'b1;
              sd_reg <= 8'h00;
              step_reg <= 4'h0;
            end
          end
          default: begin
            if (cmd_reg == 2'h0) begin
              step_reg <= 4'h0;
            end
          end
        endcase
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = 1'b0;
  assign bus.wr_en = wr_en_reg;
  assign bus.rd_en = rd_en_reg;
  assign bus.addr = sa_reg;
  assign bus.wdata = sd_reg;
  assign bus.done_clr = clr_reg;
endmodule : deac_host
`default_nettype wire

// >>> sim/deac_assertions.sv
// concurrent checks on the special register port between host and controller
`timescale 1ns/1ps
`default_nettype none
module deac_assertions
  import deac_pkg::*;
#(
  parameter int POWERUP_DELAY_TIMER_CYC = 60,
  parameter int WRITE_CYC = 10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // special register port
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic done_flag,
  input wire logic done_clr
);
  localparam int WLO = WRITE_CYC - 1;
  localparam int WHI = WRITE_CYC + 10;
  localparam int WDROP = WRITE_CYC + 14;
  logic pdrop;
  logic [31:0] up_cnt;
  logic key1;
  logic key2;
  logic trg;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since reset release; saturates so a long run cannot wrap into the blocked window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt <= 32'h0;
    end else if (up_cnt != 32'hFFFFFFFF) begin
      up_cnt <= up_cnt + 32'h1;
    end
  end
  // decoded unlock steps and the write trigger
  assign key1 = wr_en && addr == DEAC_OFS_KEY && wdata == DEAC_KEY_FIRST;
  assign key2 = wr_en && addr == DEAC_OFS_KEY && wdata == DEAC_KEY_SECOND;
  assign trg = wr_en && addr == DEAC_OFS_CTRL && wdata[DEAC_BIT_WR] && wdata[DEAC_BIT_PERMIT];
  assign pdrop = wr_en && addr == DEAC_OFS_CTRL && !wdata[DEAC_BIT_PERMIT];
  property p_permit_drop;
    trg |-> ##[1:WDROP] pdrop;
  endproperty
  a_permit_drop: assert property (p_permit_drop) else $error("write permit left set");
  property p_key_order;
    key2 |-> $past(key1, 3);
  endproperty
  a_key_order: assert property (p_key_order) else $error("second key not after first");
  property p_trg_order;
    trg |-> $past(key2, 3);
  endproperty
  a_trg_order: assert property (p_trg_order) else $error("trigger spacing wrong");
  property p_key_zero;
    addr == DEAC_OFS_KEY |=> rdata == 8'h00;
  endproperty
  a_key_zero: assert property (p_key_zero) else $error("unlock register not zero");
  property p_ctrl_upper;
    addr == DEAC_OFS_CTRL |=> rdata[7:4] == 4'h0;
  endproperty
  a_ctrl_upper: assert property (p_ctrl_upper) else $error("control upper bits set");
  property p_done_clear;
    $fell(done_flag) |-> $past(done_clr);
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag dropped alone");
  property p_done_early;
    trg |=> (!$rose(done_flag))[*8];
  endproperty
  a_done_early: assert property (p_done_early) else $error("write ended too soon");
  property p_done_time;
    trg && !done_flag && up_cnt > POWERUP_DELAY_TIMER_CYC + 4 |-> ##[WLO:WHI] $rose(done_flag);
  endproperty
  a_done_time: assert property (p_done_time) else $error("write did not end in time");
  property p_powerup_delay_timer_block;
    trg && !done_flag && up_cnt + 4 < POWERUP_DELAY_TIMER_CYC |-> ##WHI !done_flag;
  endproperty
  a_powerup_delay_timer_block: assert property (p_powerup_delay_timer_block) else $error("write during power-up delay");
  // main scenarios reached
  c_write: cover property (trg ##[WLO:WHI] $rose(done_flag));
  c_clear: cover property (done_flag && done_clr);
  c_blocked: cover property (trg && up_cnt + 4 < POWERUP_DELAY_TIMER_CYC);
endmodule : deac_assertions
`default_nettype wire

// >>> sim/data_eeprom_access_controller_bench.sv
// self-checking bench: apb host and controller joined over the register port
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_access_controller_bench;
  import deac_pkg::*;
  localparam int PW = 60;
  localparam int WC = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic master_clear_reset, watchdog_timer, brownout_detect, power_on, fuse, prog_rd;
  logic prog_q = 1'b0;
  logic [7:0] prog_addr, prog_rdata;
  logic [7:0] mem [256];
  logic [7:0] used [$];
  logic [31:0] exp_q [$];
  logic [31:0] msk_q [$];
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  deac_if i_deac_if ();
  deac_host i_deac_host (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(i_deac_if));
  deac_dev #(.LARGE(1'b1), .POWERUP_DELAY_TIMER_CYC(PW), .WRITE_CYC(WC)) i_deac_dev (.pclk(pclk),
    .presetn(presetn), .clk_en(1'b1), .master_clear_reset(master_clear_reset),
    .watchdog_timer(watchdog_timer), .brownout_detect(brownout_detect), .power_on(power_on),
    .data_protect_fuse(fuse), .prog_rd(prog_rd), .prog_addr(prog_addr),
    .prog_rdata(prog_rdata), .bus(i_deac_if));
  deac_assertions #(.POWERUP_DELAY_TIMER_CYC(PW), .WRITE_CYC(WC)) i_deac_assertions (.pclk(pclk),
    .presetn(presetn), .wr_en(i_deac_if.wr_en), .rd_en(i_deac_if.rd_en),
    .addr(i_deac_if.addr), .wdata(i_deac_if.wdata), .rdata(i_deac_if.rdata),
    .done_flag(i_deac_if.done_flag), .done_clr(i_deac_if.done_clr));
  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // note an expected masked read, then perform it
  task automatic rd_exp(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
    msk_q.push_back(m);
    exp_q.push_back(v);
    apb(1'b0, a, 32'h0);
  endtask : rd_exp
  task automatic start_wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, DEAC_HOFS_ADDR, {24'h0, a});
    apb(1'b1, DEAC_HOFS_WDATA, {24'h0, d});
    apb(1'b1, DEAC_HOFS_CMD, {30'h0, DEAC_CMD_WRITE});
  endtask : start_wr
  task automatic wait_idle();
    do apb(1'b0, DEAC_HOFS_STAT, 32'h0); while (rv[0] !== 1'b0);
  endtask : wait_idle
  // finish a write: done flag set, cleared by command, then low
  task automatic finish_wr(input logic [7:0] a, input logic [7:0] d);
    wait_idle();
    mem[a] = d;
    rd_exp(DEAC_HOFS_STAT, 32'h4, 32'h4);
    apb(1'b1, DEAC_HOFS_CMD, {30'h0, DEAC_CMD_CLRFLAG});
    wait_idle();
    rd_exp(DEAC_HOFS_STAT, 32'h4, 32'h0);
  endtask : finish_wr
  task automatic ee_write(input logic [7:0] a, input logic [7:0] d);
    start_wr(a, d);
    finish_wr(a, d);
    used.push_back(a);
  endtask : ee_write
  task automatic ee_read(input logic [7:0] a);
    apb(1'b1, DEAC_HOFS_ADDR, {24'h0, a});
    apb(1'b1, DEAC_HOFS_CMD, {30'h0, DEAC_CMD_READ});
    wait_idle();
    rd_exp(DEAC_HOFS_WDATA, 32'hFF, {24'h0, mem[a]});
  endtask : ee_read
  task automatic prog_read(input logic [7:0] a, input logic [7:0] want);
    exp_q.push_back({24'h0, want});
    msk_q.push_back(32'hFFFFFFFF);
    prog_addr <= a;
    prog_rd <= 1'b1;
    @(posedge pclk);
    prog_rd <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : prog_read
  // reset pulse; causes are dropped as reset is released
  task automatic do_reset(input int settle);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    {master_clear_reset, watchdog_timer, brownout_detect} <= 3'h0;
    presetn <= 1'b1;
    repeat (settle) @(posedge pclk);
  endtask : do_reset
  // oldest note against each completed apb read or programmer read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      check("apb read", prdata & msk_q.pop_front(), exp_q.pop_front());
    end
    if (prog_q === 1'b1) begin
      check("programmer read", {24'h0, prog_rdata}, exp_q.pop_front() & msk_q.pop_front());
    end
    prog_q <= prog_rd;
  end
  // cycle ceiling; the tests need under two thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    {psel, penable, pwrite, presetn, prog_rd, fuse} = 6'h0;
    {master_clear_reset, watchdog_timer, brownout_detect} = 3'h0;
    power_on = 1'b1;
    paddr = 12'h0;
    pwdata = 32'h0;
    prog_addr = 8'h0;
    void'($urandom(32'h70A8));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    power_on <= 1'b0;
    repeat (PW + 10) @(posedge pclk);
    // boundary locations, then random ones, then read all back
    ee_write(8'h00, 8'h5A);
    ee_write(8'hFF, 8'hA5);
    for (int i = 0; i < 6; i++) ee_write(8'($urandom), 8'($urandom));
    foreach (used[i]) ee_read(used[i]);
    // second command while busy is refused and must not alter the write
    start_wr(8'h11, 8'h96);
    apb(1'b1, DEAC_HOFS_WDATA, 32'h69);
    apb(1'b1, DEAC_HOFS_CMD, {30'h0, DEAC_CMD_WRITE});
    finish_wr(8'h11, 8'h96);
    ee_read(8'h11);
    // protection hides contents from the programmer only
    fuse <= 1'b1;
    prog_read(8'h00, 8'h00);
    ee_read(8'h00);
    fuse <= 1'b0;
    prog_read(8'h00, mem[8'h00]);
    // write issued inside the power-up delay leaves the array alone
    do_reset(1);
    start_wr(8'h00, 8'hC3);
    repeat (45) @(posedge pclk);
    do_reset(PW + 10);
    ee_read(8'h00);
    // each aborting reset cause in mid-write, then recovery
    for (int k = 0; k < 3; k++) begin
      start_wr(8'h22, 8'($urandom));
      repeat (16) @(posedge pclk);
      {master_clear_reset, watchdog_timer, brownout_detect} <= 3'(3'h1 << k);
      @(posedge pclk);
      do_reset(PW + 10);
      rd_exp(DEAC_HOFS_STAT, 32'h2, 32'h2);
      ee_write(8'h22, 8'($urandom));
      rd_exp(DEAC_HOFS_STAT, 32'h2, 32'h0);
      ee_read(8'h22);
    end
    close_out();
  end
endmodule : data_eeprom_access_controller_bench
`default_nettype wire
